// ==== cfm_pkg.sv ====
// Package for the configuration management port: widths, field positions, timing.
`default_nettype none
package cfm_pkg;
  localparam int ADDR_W       = 18;
  localparam int REG_LSB      = 0;
  localparam int REG_W        = 10;
  localparam int FUNC_LSB     = 10;
  localparam int FUNC_W       = 8;
  localparam int DATA_W       = 32;
  localparam int BE_W         = 4;
  localparam int NUM_FUNC     = 2;
  localparam int REGS_PER_FN  = 64;
  localparam int WR_LAT       = 3;
  localparam int RD_LAT       = 1;
  localparam logic [31:0] RST_VAL = 32'h0000_0000;
  // Type-1 header dword holding fields that are read-only unless overridden
  localparam logic [9:0]  T1_RO_REG  = 10'h002;
  localparam logic [31:0] T1_RO_MASK = 32'hFFFF_0000;
endpackage : cfm_pkg
`default_nettype wire

// ==== cfm_if.sv ====
// Interface joining the requester and the configuration space ends.
`timescale 1ns/1ns
`default_nettype none
interface cfm_if;
  logic [17:0] addr;
  logic [31:0] write_data;
  logic [3:0]  byte_enable;
  logic        write;
  logic        read;
  logic        type1_readonly_override;
  logic [31:0] read_data;
  logic        read_write_done;
  modport dev (input addr, write_data, byte_enable, write, read, type1_readonly_override,
               output read_data, read_write_done);
  modport req (output addr, write_data, byte_enable, write, read, type1_readonly_override,
               input read_data, read_write_done);
endinterface : cfm_if
`default_nettype wire

// ==== cfm_dev.sv ====
// Configuration space end of the management port.
// Notes on behaviour
// - Addresses are dword addresses, never bytes
// - Bits 9:0 register, bits 17:10 function
// - Read data valid while done strobe high
// - Write: address, data, byte mask, request
// - Done strobe after write completes, delayed
// - Requester holds inputs stable until done
// - Requester drops request cycle after done
// - Root port override writes read-only fields
// - Root port programs space through this port
`timescale 1ns/1ns
`default_nettype none
module cfm_dev #(
  parameter int NUM_FUNC    = cfm_pkg::NUM_FUNC,
  parameter int REGS_PER_FN = cfm_pkg::REGS_PER_FN,
  parameter int WR_LAT      = cfm_pkg::WR_LAT,
  parameter bit ROOT_PORT   = 1'b1
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic arst_n,
  // Link to the requester
  cfm_if.dev        port
);
  localparam int DEPTH = NUM_FUNC * REGS_PER_FN;
  localparam int CW    = $clog2(WR_LAT + 1);

  // Refuse sizes that the decode, the storage or the counter cannot serve
  if (NUM_FUNC < 1 || NUM_FUNC > 256) begin : g_bad_func
    $error("cfm_dev: NUM_FUNC must lie in 1..256");
  end
  if (REGS_PER_FN < 1 || REGS_PER_FN > 1024) begin : g_bad_regs
    $error("cfm_dev: REGS_PER_FN must lie in 1..1024");
  end
  if (WR_LAT < 1 || WR_LAT > 255) begin : g_bad_lat
    $error("cfm_dev: WR_LAT must lie in 1..255");
  end
  if (cfm_pkg::REG_W + cfm_pkg::FUNC_W != cfm_pkg::ADDR_W) begin : g_bad_addr
    $error("cfm_dev: register and function fields must fill the address");
  end

  // Handshake states, one-hot
  typedef enum logic [3:0] {
    CFM_IDLE  = 4'b0001,
    CFM_WBUSY = 4'b0010,
    CFM_DONE  = 4'b0100,
    CFM_WAIT  = 4'b1000
  } cfm_state_t;

  // Handshake and storage state
  cfm_state_t          state_reg;
  logic [31:0]         mem [DEPTH];
  logic [31:0]         rdata_reg;
  logic                done_reg;
  logic [CW-1:0]       cnt_reg;
  // Request as taken in the idle state
  logic [17:0]         req_addr_reg;
  logic [31:0]         req_wdata_reg;
  logic [3:0]          req_be_reg;
  logic                req_ovr_reg;
  logic                req_wr_reg;
  // Decode of the taken request
  logic [9:0]          reg_sel;
  logic [7:0]          fn_sel;
  logic                hit;
  int unsigned         idx;
  logic [31:0]         cur;
  logic [31:0]         merged;
  logic                take;

  // True when the function and register fields name a stored dword
  function automatic logic is_mapped(input logic [7:0] fn, input logic [9:0] rg);
    is_mapped = (32'(fn) < NUM_FUNC) && (32'(rg) < REGS_PER_FN);
  endfunction : is_mapped

  // Flat storage index; functions are laid out one after the other
  function automatic int unsigned flat_index(input logic [7:0] fn, input logic [9:0] rg);
    flat_index = 32'(fn) * REGS_PER_FN + 32'(rg);
  endfunction : flat_index

  // Byte-lane merge; bits set in ro keep their old value
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be, input logic [31:0] ro);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    merge_bytes = (r & ~ro) | (old & ro);
  endfunction : merge_bytes

  // Split the taken dword address into register and function fields
  assign reg_sel = req_addr_reg[cfm_pkg::REG_LSB +: cfm_pkg::REG_W];
  assign fn_sel  = req_addr_reg[cfm_pkg::FUNC_LSB +: cfm_pkg::FUNC_W];
  assign hit     = is_mapped(fn_sel, reg_sel);
  assign idx     = hit ? flat_index(fn_sel, reg_sel) : 32'h0000_0000;
  assign cur     = mem[idx];

  // A request is taken only in the idle state; a write wins over a read
  assign take = (state_reg == CFM_IDLE) && (port.write || port.read);

  // Request captured when taken; the held inputs are not read again, so a
  // requester that lets them move early cannot steer a write to another place
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      req_addr_reg  <= '0;
      req_wdata_reg <= '0;
      req_be_reg    <= '0;
      req_ovr_reg   <= 1'b0;
      req_wr_reg    <= 1'b0;
    end else if (take) begin
      req_addr_reg  <= port.addr;
      req_wdata_reg <= port.write_data;
      req_be_reg    <= port.byte_enable;
      req_ovr_reg   <= port.type1_readonly_override;
      req_wr_reg    <= port.write;
    end
  end

  // Lane merge; read-only bits of the type-1 dword kept unless overridden
  always_comb begin
    if (reg_sel == cfm_pkg::T1_RO_REG && !(ROOT_PORT && req_ovr_reg)) begin
      merged = merge_bytes(cur, req_wdata_reg, req_be_reg, cfm_pkg::T1_RO_MASK);
    end else begin
      merged = merge_bytes(cur, req_wdata_reg, req_be_reg, 32'h0000_0000);
    end
  end

  // Handshake sequencing
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= CFM_IDLE;
    end else begin
      case (state_reg)
        // Wait for a request; a write takes the latency path
        CFM_IDLE: begin
          if (port.write) begin
            state_reg <= CFM_WBUSY;
          end else if (port.read) begin
            state_reg <= CFM_DONE;
          end
        end
        // Write in progress until the latency counter runs out
        CFM_WBUSY: begin
          if (cnt_reg == '0) begin
            state_reg <= CFM_DONE;
          end
        end
        // Access lands; the done strobe rises at the next edge
        CFM_DONE: begin
          state_reg <= CFM_WAIT;
        end
        // Done strobe high; the requester drops its request here
        CFM_WAIT: begin
          state_reg <= CFM_IDLE;
        end
        default: begin
          state_reg <= CFM_IDLE;
        end
      endcase
    end
  end

  // Write latency counter, loaded when a write is taken
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
    end else if (take && port.write) begin
      cnt_reg <= CW'(WR_LAT - 1);
    end else if (state_reg == CFM_WBUSY && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // Done strobe, one cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (state_reg == CFM_DONE);
    end
  end

  // Read data launched together with the done strobe, held until the next read
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= cfm_pkg::RST_VAL;
    end else if (state_reg == CFM_DONE && !req_wr_reg) begin
      rdata_reg <= hit ? cur : cfm_pkg::RST_VAL;
    end
  end

  // Storage; write lands when the done strobe is produced, unmapped places dropped
  always_ff @(posedge mclk) begin
    if (state_reg == CFM_DONE && req_wr_reg && hit) begin
      mem[idx] <= merged;
    end
  end

  // Outputs straight from their flip-flops
  assign port.read_data       = rdata_reg;
  assign port.read_write_done = done_reg;
endmodule : cfm_dev
`default_nettype wire

// ==== cfm_req.sv ====
// Requester end: turns single-cycle user commands into held handshakes.
`timescale 1ns/1ns
`default_nettype none
module cfm_req (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // User command side
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [17:0] cmd_addr,
  input  wire logic [31:0] cmd_wdata,
  input  wire logic [3:0]  cmd_be,
  input  wire logic        cmd_override,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic [31:0]      rsp_rdata,
  // Link to the configuration space
  cfm_if.req               port
);
  logic        busy_reg;
  logic        wr_reg;
  logic        rd_reg;
  logic        ovr_reg;
  logic [17:0] addr_reg;
  logic [31:0] wd_reg;
  logic [3:0]  be_reg;
  logic        rsp_reg;
  logic [31:0] rd_data_reg;

  // Hold request until the done strobe, drop it the next cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg <= 1'b0;
      wr_reg   <= 1'b0;
      rd_reg   <= 1'b0;
      ovr_reg  <= 1'b0;
      addr_reg <= 18'h0_0000;
      wd_reg   <= 32'h0000_0000;
      be_reg   <= 4'h0;
    end else if (busy_reg) begin
      if (port.read_write_done) begin
        busy_reg <= 1'b0;
        wr_reg   <= 1'b0;
        rd_reg   <= 1'b0;
        ovr_reg  <= 1'b0;
      end
    end else if (cmd_valid) begin
      busy_reg <= 1'b1;
      wr_reg   <= cmd_write;
      rd_reg   <= !cmd_write;
      ovr_reg  <= cmd_override;
      addr_reg <= cmd_addr;        // Dword address
      wd_reg   <= cmd_wdata;
      be_reg   <= cmd_be;
    end
  end

  // Response capture while done strobe is high
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_reg     <= 1'b0;
      rd_data_reg <= 32'h0000_0000;
    end else begin
      rsp_reg <= busy_reg && port.read_write_done;
      if (busy_reg && port.read_write_done && rd_reg) begin
        rd_data_reg <= port.read_data;
      end
    end
  end

  assign cmd_ready                    = !busy_reg;
  assign rsp_valid                    = rsp_reg;
  assign rsp_rdata                    = rd_data_reg;
  assign port.addr                    = addr_reg;
  assign port.write_data              = wd_reg;
  assign port.byte_enable             = be_reg;
  assign port.write                   = wr_reg;
  assign port.read                    = rd_reg;
  assign port.type1_readonly_override = ovr_reg;
endmodule : cfm_req
`default_nettype wire

// ==== cfm_checker.sv ====
// Checker for the handshake between the requester and configuration space ends.
`timescale 1ns/1ns
`default_nettype none
module cfm_checker (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        arst_n,
  // Interface signals
  input wire logic [17:0] addr,
  input wire logic [31:0] write_data,
  input wire logic [3:0]  byte_enable,
  input wire logic        write,
  input wire logic        read,
  input wire logic        type1_readonly_override,
  input wire logic [31:0] read_data,
  input wire logic        read_write_done
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Completion waits for each request kind
  sequence rd_wait_s; !read_write_done[*2] ##1 read_write_done; endsequence
  sequence wr_wait_s; !read_write_done[*5] ##1 read_write_done; endsequence
  rd_latency_a: assert property ($rose(read) |-> rd_wait_s) else $error("read done off");
  wr_latency_a: assert property ($rose(write) |-> wr_wait_s) else $error("write done off");
  done_pulse_a: assert property (read_write_done |=> !read_write_done) else $error("done wide");
  wr_hold_a: assert property (write && !read_write_done |=> write && $stable(addr) &&
    $stable(write_data) && $stable(byte_enable) && $stable(type1_readonly_override))
    else $error("write moved");
  wr_drop_a: assert property (write && read_write_done |=> !write) else $error("write kept");
  rd_hold_a: assert property (read && !read_write_done |=> read && $stable(addr))
    else $error("read moved");
  rd_drop_a: assert property (read && read_write_done |=> !read) else $error("read kept");
  rd_keep_a: assert property (read && read_write_done |=> $stable(read_data))
    else $error("data moved");
endmodule : cfm_checker
`default_nettype wire

// ==== config_space_mgmt_port_tb.sv ====
// Testbench joining both ends of the management port against a reference model.
`timescale 1ns/1ns
`default_nettype none
module config_space_mgmt_port_tb;
  logic        mclk = 1'b0, arst_n = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0;
  logic        cmd_override = 1'b0, cmd_ready, rsp_valid, ov, hit;
  logic [17:0] cmd_addr = 18'h0_0000, a;
  logic [31:0] cmd_wdata = 32'h0000_0000, rsp_rdata, seed = 32'h0000_0016, r, d, v, old;
  logic [3:0]  cmd_be = 4'h0, be;
  logic [31:0] last = 32'h0000_0000;
  logic [31:0] mem [int];
  int          fails = 0, checked = 0, cyc = 0;
  cfm_if ifc ();
  cfm_dev cfm_dev_inst (.mclk(mclk), .arst_n(arst_n), .port(ifc.dev));
  cfm_req cfm_req_inst (.mclk(mclk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_be(cmd_be),
    .cmd_override(cmd_override), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .port(ifc.req));
  cfm_checker cfm_checker_inst (.mclk(mclk), .arst_n(arst_n), .addr(ifc.addr),
    .write_data(ifc.write_data), .byte_enable(ifc.byte_enable), .write(ifc.write),
    .read(ifc.read), .type1_readonly_override(ifc.type1_readonly_override),
    .read_data(ifc.read_data), .read_write_done(ifc.read_write_done));
  // Clock and watchdog
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      finish_test();
    end
  end
  // Xorshift source
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // One user command, waits for its response
  task automatic op(input logic w, input logic [17:0] ad, input logic [31:0] wd,
                    input logic [3:0] b, input logic o);
    int n;
    n = 0;
    check({31'h0000_0000, cmd_ready}, 32'h0000_0001);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= ad;
    cmd_wdata <= wd;
    cmd_be <= b;
    cmd_override <= o;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    do begin
      @(posedge mclk);
      n++;
    end while (rsp_valid !== 1'b1);
    // Take and report cost three edges, a write one more for its done stage
    check(n, w ? cfm_pkg::WR_LAT + 4 : cfm_pkg::RD_LAT + 3);
    @(posedge mclk);
    check({31'h0000_0000, rsp_valid}, 32'h0000_0000);
  endtask : op
  // Verdict
  task automatic finish_test();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  // Random writes with read-back, mapped and unmapped places
  initial begin
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    // Fill every mapped dword on all lanes with the override, so none stays unknown
    for (int f = 0; f < cfm_pkg::NUM_FUNC; f++) begin
      for (int g = 0; g < cfm_pkg::REGS_PER_FN; g++) begin
        a = {8'(f), 10'(g)};
        d = xs();
        mem[a] = d;
        op(1'b1, a, d, 4'hf, 1'b1);
        check(rsp_rdata, last);
      end
    end
    $display("fill test done");
    for (int k = 0; k < 40; k++) begin
      r = xs();
      a = {6'h00, r[12:11], r[10] ? 10'h002 : {3'h0, r[9], r[5:0]}};
      d = xs();
      be = r[16:13];
      ov = r[17];
      hit = (a[17:10] < cfm_pkg::NUM_FUNC) && (a[9:0] < cfm_pkg::REGS_PER_FN);
      old = mem.exists(a) ? mem[a] : 32'h0000_0000;
      v = old;
      for (int i = 0; i < 4; i++) begin
        if (be[i]) v[8*i +: 8] = d[8*i +: 8];
      end
      if (a[9:0] == cfm_pkg::T1_RO_REG && !ov) begin
        v = (v & ~cfm_pkg::T1_RO_MASK) | (old & cfm_pkg::T1_RO_MASK);
      end
      if (hit) mem[a] = v;
      op(1'b1, a, d, be, ov);
      check(rsp_rdata, last);
      op(1'b0, a, 32'h0000_0000, 4'h0, 1'b0);
      last = hit ? v : 32'h0000_0000;
      check(rsp_rdata, last);
    end
    $display("random write and read-back test done");
    finish_test();
  end
endmodule : config_space_mgmt_port_tb
`default_nettype wire
